// ===== shared/trpd_pkg.sv
package trpd_pkg;

  // ************************************************************
  // Block geometry
  // ************************************************************
  localparam int unsigned NUM_CHANNELS = 4;
  localparam int unsigned NUM_PLLS     = 2;

  // ************************************************************
  // Input conditioning
  // ************************************************************
  localparam int unsigned SYNC_STAGES  = 3;
  localparam logic [2:0]  SYNC_RESET   = 3'h7;

  // ************************************************************
  // Per-channel hold vector field positions
  // ************************************************************
  localparam int unsigned HOLD_TX_PHASE_FIFO  = 0;
  localparam int unsigned HOLD_TX_BYTE_SER    = 1;
  localparam int unsigned HOLD_TX_ENCODER     = 2;
  localparam int unsigned HOLD_TX_SERIALIZER  = 3;
  localparam int unsigned HOLD_TX_XAUI_SM     = 4;
  localparam int unsigned HOLD_TX_BUFFER      = 5;
  localparam int unsigned HOLD_RX_BUFFER      = 6;
  localparam int unsigned HOLD_RX_CLK_RECOVERY = 7;
  localparam int unsigned HOLD_RX_DESER       = 8;
  localparam int unsigned HOLD_RX_ALIGNER     = 9;
  localparam int unsigned HOLD_RX_DESKEW      = 10;
  localparam int unsigned HOLD_RX_RATE_COMP   = 11;
  localparam int unsigned HOLD_RX_DECODER     = 12;
  localparam int unsigned HOLD_RX_BYTE_DESER  = 13;
  localparam int unsigned HOLD_RX_BYTE_ORDER  = 14;
  localparam int unsigned HOLD_RX_PHASE_FIFO  = 15;
  localparam int unsigned HOLD_RX_XAUI_SM     = 16;
  localparam int unsigned HOLD_RX_SELF_TEST   = 17;
  localparam int unsigned HOLD_WIDTH          = 18;

  // ************************************************************
  // Source masks
  // ************************************************************
  localparam logic [17:0] MASK_TX_DIGITAL = 18'h0001F;
  localparam logic [17:0] MASK_RX_ANALOG  = 18'h00080;
  localparam logic [17:0] MASK_RX_DIGITAL = 18'h3FE00;
  localparam logic [17:0] MASK_POWERDOWN  = 18'h3FFFF;
  localparam logic [17:0] HOLD_RESET      = 18'h3FFFF;

endpackage : trpd_pkg

// ===== rtl/trpd_sync.sv
`timescale 1ns/10ps
`default_nettype none
module trpd_sync
  import trpd_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] level_out
);

  // ************************************************************
  // Three-stage capture, change taken when stages two and three agree
  // ************************************************************
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;
  logic [WIDTH-1:0] lvl_d;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("trpd_sync WIDTH must be at least 1");
  end

  always_comb
  begin
    lvl_d = lvl_q;
    for (int i = 0; i < int'(WIDTH); i++)
    begin
      if (s2_q[i] == s3_q[i])
        lvl_d[i] = s3_q[i];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q  <= {WIDTH{1'b1}};
      s2_q  <= {WIDTH{1'b1}};
      s3_q  <= {WIDTH{1'b1}};
      lvl_q <= {WIDTH{1'b1}};
    end
    else
    begin
      s1_q  <= async_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;

endmodule : trpd_sync
`default_nettype wire

// ===== rtl/trpd_fanout.sv
`timescale 1ns/10ps
`default_nettype none
module trpd_fanout
  import trpd_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_CHANNELS,
  parameter int unsigned PLLS     = NUM_PLLS
)
(
  input  wire logic                           clk_sys,
  input  wire logic                           resetn,
  input  wire logic [CHANNELS-1:0]            rx_digital_reset,
  input  wire logic [CHANNELS-1:0]            rx_analog_reset,
  input  wire logic [CHANNELS-1:0]            tx_digital_reset,
  input  wire logic [PLLS-1:0]                pll_power_down,
  input  wire logic                           block_power_down,
  output var  logic [CHANNELS*HOLD_WIDTH-1:0] channel_hold,
  output var  logic [PLLS-1:0]                clock_multiplier_unit_hold,
  output var  logic [CHANNELS-1:0]            clock_data_recovery_hold,
  output var  logic [CHANNELS-1:0]            self_test_engine_hold,
  output var  logic                           block_ready
);

  // ************************************************************
  // Parameter check
  // ************************************************************
  if (CHANNELS < 1)
  begin : g_bad_channels
    $error("trpd_fanout needs at least one channel");
  end

  if (PLLS < 1)
  begin : g_bad_plls
    $error("trpd_fanout needs at least one PLL");
  end

  if ($bits(MASK_POWERDOWN) != HOLD_WIDTH)
  begin : g_bad_hold_map
    $error("trpd_fanout hold masks must match the hold vector width");
  end

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_meta_d;
  logic rst_meta_q;
  logic rst_n_d;
  logic rst_n_q;

  always_comb
  begin
    rst_meta_d = 1'b1;
    rst_n_d    = rst_meta_q;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= rst_meta_d;
      rst_n_q    <= rst_n_d;
    end
  end

  // ************************************************************
  // Input conditioning
  // ************************************************************
  localparam int unsigned IN_W = 3 * CHANNELS + PLLS + 1;

  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] clean_in;
  logic [CHANNELS-1:0] rxd_s;
  logic [CHANNELS-1:0] rxa_s;
  logic [CHANNELS-1:0] txd_s;
  logic [PLLS-1:0]     pll_s;
  logic                pwr_s;

  assign raw_in = {block_power_down, pll_power_down, tx_digital_reset, rx_analog_reset, rx_digital_reset};

  trpd_sync #(
    .WIDTH (IN_W)
  ) u_sync (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n_q),
    .async_in  (raw_in),
    .level_out (clean_in)
  );

  assign rxd_s = clean_in[CHANNELS-1:0];
  assign rxa_s = clean_in[2*CHANNELS-1:CHANNELS];
  assign txd_s = clean_in[3*CHANNELS-1:2*CHANNELS];
  assign pll_s = clean_in[3*CHANNELS+PLLS-1:3*CHANNELS];
  assign pwr_s = clean_in[IN_W-1];

  // ************************************************************
  // Channel hold fan-out
  // ************************************************************
  logic [CHANNELS*HOLD_WIDTH-1:0] hold_d;
  logic [CHANNELS*HOLD_WIDTH-1:0] hold_q;

  always_comb
  begin
    logic [HOLD_WIDTH-1:0] ch;
    ch     = '0;
    hold_d = '0;
    for (int c = 0; c < int'(CHANNELS); c++)
    begin
      ch = '0;
      if (txd_s[c])
        ch = ch | MASK_TX_DIGITAL;
      if (rxd_s[c])
        ch = ch | MASK_RX_DIGITAL;
      if (rxa_s[c])
        ch = ch | MASK_RX_ANALOG;
      if (pwr_s)
        ch = ch | MASK_POWERDOWN;
      hold_d[c*HOLD_WIDTH +: HOLD_WIDTH] = ch;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
      hold_q <= {CHANNELS{HOLD_RESET}};
    else
      hold_q <= hold_d;
  end

  // ************************************************************
  // Multiplier PLL holds
  // ************************************************************
  logic [PLLS-1:0] pll_d;
  logic [PLLS-1:0] pll_q;

  always_comb
  begin
    pll_d = pll_s | {PLLS{pwr_s}};
  end

  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
      pll_q <= {PLLS{1'b1}};
    else
      pll_q <= pll_d;
  end

  // ************************************************************
  // Clock recovery and self-test copies
  // ************************************************************
  logic [CHANNELS-1:0] recovery_d;
  logic [CHANNELS-1:0] recovery_q;
  logic [CHANNELS-1:0] self_test_d;
  logic [CHANNELS-1:0] self_test_q;

  always_comb
  begin
    recovery_d  = '0;
    self_test_d = '0;
    for (int c = 0; c < int'(CHANNELS); c++)
    begin
      recovery_d[c]  = hold_d[c*HOLD_WIDTH + HOLD_RX_CLK_RECOVERY];
      self_test_d[c] = hold_d[c*HOLD_WIDTH + HOLD_RX_SELF_TEST];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      recovery_q  <= {CHANNELS{1'b1}};
      self_test_q <= {CHANNELS{1'b1}};
    end
    else
    begin
      recovery_q  <= recovery_d;
      self_test_q <= self_test_d;
    end
  end

  // ************************************************************
  // Block ready
  // ************************************************************
  logic ready_d;
  logic ready_q;

  always_comb
  begin
    ready_d = ~(|hold_d) & ~(|pll_d);
  end

  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
      ready_q <= 1'b0;
    else
      ready_q <= ready_d;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign channel_hold               = hold_q;
  assign clock_multiplier_unit_hold = pll_q;
  assign clock_data_recovery_hold   = recovery_q;
  assign self_test_engine_hold      = self_test_q;
  assign block_ready                = ready_q;

endmodule : trpd_fanout
`default_nettype wire

// ===== verif/trpd_fanout_checker.sv
`timescale 1ns/10ps
`default_nettype none
// **********
// Hold checks
// **********
module trpd_fanout_checker
  import trpd_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_CHANNELS,
  parameter int unsigned PLLS     = NUM_PLLS
)
(
  input wire logic                           clk_sys,
  input wire logic                           resetn,
  input wire logic [CHANNELS-1:0]            rx_digital_reset,
  input wire logic [CHANNELS-1:0]            rx_analog_reset,
  input wire logic [CHANNELS-1:0]            tx_digital_reset,
  input wire logic [PLLS-1:0]                pll_power_down,
  input wire logic                           block_power_down,
  input wire logic [CHANNELS*HOLD_WIDTH-1:0] channel_hold,
  input wire logic [PLLS-1:0]                clock_multiplier_unit_hold,
  input wire logic [CHANNELS-1:0]            clock_data_recovery_hold,
  input wire logic [CHANNELS-1:0]            self_test_engine_hold,
  input wire logic                           block_ready
);
  logic [14:0] in_w;
  logic        any_in;
  logic [3:0]  up_q;
  logic [3:0]  up_d;
  assign in_w = {block_power_down, pll_power_down, tx_digital_reset, rx_analog_reset, rx_digital_reset};
  assign any_in = |in_w;
  always_comb up_d = (up_q == 4'hF) ? up_q : up_q + 4'h1;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      up_q <= 4'h0;
    else
      up_q <= up_d;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn || up_q != 4'hF);
  AST_TX_ONLY: assert property ((in_w == 15'h0200) [*7] |-> channel_hold[35:0] == 36'h7C0000)
    else $error("tx hold wrong");
  AST_RXD_ONLY: assert property ((in_w == 15'h0004) [*7] |-> channel_hold[53:36] == 18'h3FE00)
    else $error("rx digital hold wrong");
  AST_RXA_ONLY: assert property ((in_w == 15'h0080) [*7] |->
    channel_hold == {18'h00080, 54'h0} && clock_data_recovery_hold == 4'h8)
    else $error("rx analog hold wrong");
  AST_PLL_ONLY: assert property ((in_w == 15'h2000) [*7] |->
    clock_multiplier_unit_hold == 2'h2 && channel_hold == 72'h0)
    else $error("pll hold wrong");
  AST_BLOCK: assert property (block_power_down [*7] |-> &channel_hold && &clock_multiplier_unit_hold)
    else $error("power down hold wrong");
  AST_READY_LAT: assert property ($rose(block_ready) |-> !$past(any_in, 5) && $past(any_in, 6))
    else $error("ready latency wrong");
  AST_READY_LVL: assert property (block_ready |-> channel_hold == 72'h0 && clock_multiplier_unit_hold == 2'h0)
    else $error("ready while held");
  AST_COPIES: assert property (self_test_engine_hold ==
    {channel_hold[71], channel_hold[53], channel_hold[35], channel_hold[17]})
    else $error("self test copy wrong");
endmodule : trpd_fanout_checker
bind trpd_fanout trpd_fanout_checker #(.CHANNELS(CHANNELS), .PLLS(PLLS)) u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .rx_digital_reset(rx_digital_reset), .rx_analog_reset(rx_analog_reset),
  .tx_digital_reset(tx_digital_reset), .pll_power_down(pll_power_down), .block_power_down(block_power_down),
  .channel_hold(channel_hold), .clock_multiplier_unit_hold(clock_multiplier_unit_hold),
  .clock_data_recovery_hold(clock_data_recovery_hold), .self_test_engine_hold(self_test_engine_hold),
  .block_ready(block_ready));
`default_nettype wire

// ===== verif/trpd_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// **********
// Reset controller model
// **********
module trpd_ctrl_model
  import trpd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic [14:0] want,
  output var  logic [3:0]  rx_digital_reset,
  output var  logic [3:0]  rx_analog_reset,
  output var  logic [3:0]  tx_digital_reset,
  output var  logic [1:0]  pll_power_down,
  output var  logic        block_power_down
);
  // Levels change off the falling edge, in the order commanded
  always @(negedge clk_sys)
    {block_power_down, pll_power_down, tx_digital_reset, rx_analog_reset, rx_digital_reset} <= want;
endmodule : trpd_ctrl_model
`default_nettype wire

// ===== verif/trpd_fanout_tb.sv
`timescale 1ns/10ps
`default_nettype none
// **********
// Testbench
// **********
module trpd_fanout_tb
  import trpd_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [14:0] want = 15'h0000;
  wire  [3:0]  rxd;
  wire  [3:0]  rxa;
  wire  [3:0]  txd;
  wire  [1:0]  pll;
  wire         bpd;
  logic [71:0] hold;
  logic [1:0]  pll_hold;
  logic [3:0]  rec_hold;
  logic [3:0]  st_hold;
  logic        ready;
  logic [89:0] rows [7];
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #5 clk_sys = ~clk_sys;
  trpd_ctrl_model u_ctrl (.clk_sys(clk_sys), .want(want), .rx_digital_reset(rxd), .rx_analog_reset(rxa),
    .tx_digital_reset(txd), .pll_power_down(pll), .block_power_down(bpd));
  trpd_fanout u_dut (.clk_sys(clk_sys), .resetn(resetn), .rx_digital_reset(rxd), .rx_analog_reset(rxa),
    .tx_digital_reset(txd), .pll_power_down(pll), .block_power_down(bpd), .channel_hold(hold),
    .clock_multiplier_unit_hold(pll_hold), .clock_data_recovery_hold(rec_hold), .self_test_engine_hold(st_hold),
    .block_ready(ready));
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [74:0] exp);
    logic [7:0] exp_cp;
    exp_cp = {exp[71], exp[53], exp[35], exp[17], exp[61], exp[43], exp[25], exp[7]};
    cmp_count++;
    if ({ready, pll_hold, hold} !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, {ready, pll_hold, hold}, exp);
    end
    cmp_count++;
    if ({st_hold, rec_hold} !== exp_cp)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, {st_hold, rec_hold}, exp_cp);
    end
  endtask : chk
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      end_sim();
    end
  end
  initial
  begin
    rows = '{{15'h0000, 1'b1, 2'h0, 72'h0},
      {15'h0200, 1'b0, 2'h0, 36'h0, 18'h0001F, 18'h0},
      {15'h0004, 1'b0, 2'h0, 18'h0, 18'h3FE00, 36'h0},
      {15'h0080, 1'b0, 2'h0, 18'h00080, 54'h0},
      {15'h2000, 1'b0, 2'h2, 72'h0},
      {15'h0111, 1'b0, 2'h0, 54'h0, 18'h3FE9F},
      {15'h4000, 1'b0, 2'h3, {72{1'b1}}}};
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys) resetn = 1'b1;
    repeat (12) @(posedge clk_sys);
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk_sys) want <= rows[i][89:75];
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys) chk(rows[i][74:0]);
      $display("row %0d done", i);
    end
    @(posedge clk_sys) want <= 15'h0000;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys) chk({1'b1, 2'h0, 72'h0});
    $display("release done");
    @(negedge clk_sys) resetn = 1'b0;
    @(negedge clk_sys) chk({1'b0, 2'h3, {72{1'b1}}});
    resetn = 1'b1;
    repeat (12) @(negedge clk_sys);
    chk({1'b1, 2'h0, 72'h0});
    $display("mid reset done");
    end_sim();
  end
endmodule : trpd_fanout_tb
`default_nettype wire
